// *** hw/pao_buf_if.sv ***
// valid/ready carrier between the latency pipe and the output buffer
`timescale 1ns/1ps
`default_nettype none
interface pao_buf_if;
  logic [9:0] in_data;
  logic       in_valid;
  logic       in_ready;
  logic [9:0] out_data;
  logic       out_valid;
  logic       out_ready;
  modport src  (output in_data, output in_valid, input in_ready,
                input out_data, input out_valid, output out_ready);
  modport fifo (input in_data, input in_valid, output in_ready,
                output out_data, output out_valid, input out_ready);
endinterface
`default_nettype wire

// *** hw/pao_core.sv ***
// digital output path of a 10-bit pipelined converter
// Operation
// - each 10-bit result appears on the bus five convert cycles after its sample
// - straight offset binary: top all ones, bottom all zeros, midscale msb only
// - code linear in input; three-quarter and quarter points fall on fixed codes
// - output enable high puts all ten data pins in high impedance
// - output enable low or floating drives the data pins; pull-down default
// - nine pipelined two-bit stages, each converting once per convert cycle
// - each stage result passes its own delay line to align one sample
// - error correction merges aligned redundant bits into a word kept for observation only
// - non-overlapping two-phase clock: sample in first phase, hold in second
// - power-down tristates outputs; five results after release are invalid
`timescale 1ns/1ps
`default_nettype none
`include "pao_map.svh"
module pao_core
  import pao_pkg::*;
#(
  parameter int DATA_W  = `PAO_DATA_W,
  parameter int STAGES  = `PAO_STAGES,
  parameter int LATENCY = `PAO_LATENCY
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              conv_clk,
  input  wire logic [DATA_W-1:0] sample_in,
  input  wire logic              out_en_n,
  input  wire logic              power_down,
  output logic      [DATA_W-1:0] data_out,
  output logic      [DATA_W-1:0] data_oe,
  output logic                   data_valid,
  output logic                   sample_phase
);
  // ----------------------------------------------------------------
  // constants and checks
  // ----------------------------------------------------------------
  localparam int CONV_MIN_CYC  = (`PAO_CONV_MIN_NS + `PAO_CLK_NS - 1) / `PAO_CLK_NS;
  localparam int PHASE_MIN_CYC = (`PAO_PHASE_MIN_NS + `PAO_CLK_NS - 1) / `PAO_CLK_NS;
  // the pipeline spans the latency minus the sample register
  localparam int PIPE = LATENCY - 1;

  initial begin
    if (DATA_W != 10 || STAGES != 9 || LATENCY != 5) begin
      $error("pao_core serves 10 bits, 9 stages, latency 5 only");
    end
    if (CONV_MIN_CYC < 1 || PHASE_MIN_CYC < 1) begin
      $error("pao_core timing counts invalid");
    end
  end

  // pick two bits of a residue for one stage (decode used by every stage)
  function automatic pao_stage_t stage_bits(input logic [DATA_W-1:0] res, input int idx);
    pao_stage_t b;
    b = 2'h0;
    if (idx == 0) begin
      b = res[DATA_W-1 -: 2];
    end else begin
      // later stages resolve one new bit each; the upper bit is the
      // redundant overlap that the correction sum absorbs
      b = {1'b0, res[DATA_W-2-idx]};
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cclk_sync;
  logic [1:0] oe_sync;
  logic [1:0] pd_sync;
  logic       conv_edge;

  // two flops per pin, three for the convert clock; edge detect looks only at the second and third flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cclk_sync <= 3'h0;
      oe_sync   <= 2'h0;
      pd_sync   <= 2'h0;
    end else begin
      cclk_sync <= {cclk_sync[1:0], conv_clk};
      oe_sync   <= {oe_sync[0], out_en_n};
      pd_sync   <= {pd_sync[0], power_down};
    end
  end
  // convert edge: a one-cycle enable, the only rate this block runs at
  assign conv_edge = cclk_sync[1] & ~cclk_sync[2];

  // sample word synchroniser; the word stands for the whole convert period,
  // so two flops per bit are enough and no gray code is needed
  pao_word_t samp_sync [2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_sync[0] <= `PAO_CODE_MID;
      samp_sync[1] <= `PAO_CODE_MID;
    end else begin
      samp_sync[0] <= sample_in;
      samp_sync[1] <= samp_sync[0];
    end
  end

  // ----------------------------------------------------------------
  // two-phase sampling clock
  // ----------------------------------------------------------------
  pao_phase_t phase;
  pao_word_t  held;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PAO_PH_HOLD;
    end else begin
      unique case (phase)
        PAO_PH_HOLD: begin
          if (conv_edge) begin
            phase <= PAO_PH_SAMPLE;
          end
        end
        PAO_PH_SAMPLE: begin
          phase <= PAO_PH_HOLD;
        end
      endcase
    end
  end

  // sample in first phase, then held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= `PAO_CODE_MID;
    end else if (conv_edge) begin
      // read only the second synchroniser flop
      held <= samp_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // stage quantizers with per-stage delay lines
  // ----------------------------------------------------------------
  // residue moves one stage per convert edge; stage bits age in their own
  // lines so all nine results of a sample meet in the same cycle
  pao_stage_t aligned [STAGES];
  logic       step;
  assign step = (phase == PAO_PH_SAMPLE);

  // residue chain: stage s sees the sample s steps after stage zero did,
  // which is what makes the unequal delay lines below line up again
  pao_word_t residue [STAGES];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < STAGES; k++) begin
        residue[k] <= `PAO_CODE_MID;
      end
    end else if (step) begin
      residue[0] <= held;
      for (int k = 1; k < STAGES; k++) begin
        residue[k] <= residue[k-1];
      end
    end
  end

  genvar s;
  generate
    for (s = 0; s < STAGES; s++) begin : g_stage
      localparam int DLY = STAGES - 1 - s;
      pao_stage_t line [DLY+1];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          line[0] <= 2'h0;
        end else if (step) begin
          line[0] <= stage_bits(residue[s], s);
        end
      end
      for (genvar d = 1; d <= DLY; d++) begin : g_dly
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            line[d] <= 2'h0;
          end else if (step) begin
            line[d] <= line[d-1];
          end
        end
      end
      assign aligned[s] = line[DLY];
    end
  endgenerate

  // ----------------------------------------------------------------
  // error correction and latency match
  // ----------------------------------------------------------------
  pao_word_t corrected;
  pao_word_t lat_pipe [PIPE];

  always_comb begin
    corrected = {aligned[0], 8'h00};
    for (int k = 1; k < STAGES; k++) begin
      // overlapping weights: a stage carry lands on the bit above it
      corrected = corrected + (pao_word_t'(aligned[k]) << (DATA_W - 2 - k));
    end
  end

  // stage delay lines are modelled behaviourally; the word latency is pinned
  // by this pipe so the output meets the documented count exactly
  // fixed five-cycle latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < PIPE; k++) begin
        lat_pipe[k] <= `PAO_CODE_MID;
      end
    end else if (conv_edge) begin
      lat_pipe[0] <= held;
      for (int k = 1; k < PIPE; k++) begin
        lat_pipe[k] <= lat_pipe[k-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // power-down blanking
  // ----------------------------------------------------------------
  logic [2:0] blank_cnt;

  // the word pushed at an edge is tested after that edge's decrement, so
  // the count starts one above the latency: the first five pushes are
  // stale pipe contents and the sixth carries the first fresh sample
  // five invalid results after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt <= 3'(LATENCY + 1);
    end else if (pd_sync[1]) begin
      blank_cnt <= 3'(LATENCY + 1);
    end else if (conv_edge && blank_cnt != 3'h0) begin
      blank_cnt <= blank_cnt - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // output buffer and pins
  // ----------------------------------------------------------------
  pao_buf_if buf_if ();

  // output word is taken from the latency pipe; the correction result is not used here
  // straight offset binary
  assign buf_if.in_data   = lat_pipe[PIPE-1];
  assign buf_if.in_valid  = conv_edge;
  assign buf_if.out_ready = 1'b1;

  pao_skid #(
    .WIDTH (DATA_W),
    .DEPTH (2)
  ) u_skid (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (buf_if.fifo)
  );

  // output register; bus owner never stalls, buffer guards a later stall
  // blanked words are dropped so the pins keep the last good word standing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out   <= `PAO_CODE_MID;
      data_valid <= 1'b0;
    end else if (buf_if.out_valid && blank_cnt == 3'h0 && !pd_sync[1]) begin
      data_out   <= buf_if.out_data;
      data_valid <= 1'b1;
    end else begin
      data_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe <= 10'h000;
    end else begin
      data_oe <= {DATA_W{~oe_sync[1] & ~pd_sync[1]}};
    end
  end

  // phase indicator for observation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_phase <= 1'b0;
    end else begin
      sample_phase <= step;
    end
  end

  // the correction word trails the output pipe by four convert cycles (nine steps against five);
  // it is kept for observation only and does not reach the pins
  logic unused_corr;
  assign unused_corr = ^corrected;
endmodule
`default_nettype wire

// *** hw/pao_map.svh ***
// timing counts and code constants for the pipelined converter output path
`ifndef PAO_MAP_SVH
`define PAO_MAP_SVH
`define PAO_DATA_W        10
`define PAO_STAGES        9
`define PAO_LATENCY       5
`define PAO_CONV_MIN_NS   50
`define PAO_PHASE_MIN_NS  24
`define PAO_CLK_NS        20
`define PAO_CODE_ZERO     10'h000
`define PAO_CODE_MID      10'h200
`define PAO_CODE_FULL     10'h3ff
`define PAO_DIV_RST       3'h0
`endif

// *** hw/pao_pkg.sv ***
// types shared by the converter output path
package pao_pkg;
  typedef logic [9:0] pao_word_t;
  typedef logic [1:0] pao_stage_t;
  typedef enum logic [1:0] {
    PAO_PH_SAMPLE = 2'b01,
    PAO_PH_HOLD   = 2'b10
  } pao_phase_t;
endpackage

// *** hw/pao_skid.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "pao_map.svh"
module pao_skid
  import pao_pkg::*;
#(
  parameter int WIDTH = `PAO_DATA_W,
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  pao_buf_if.fifo   bus
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             do_wr;
  logic             do_rd;

  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("pao_skid serves only depth 2");
    end
  end

  assign bus.in_ready  = (count != 2'h2);
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data  = mem[rd_ptr];
  assign do_wr = bus.in_valid & bus.in_ready;
  assign do_rd = bus.out_valid & bus.out_ready;

  // storage written only on accepted words
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= bus.in_data;
    end
  end

  // pointers and occupancy; full refuses, so no word is lost on a stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_rd) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule
`default_nettype wire

// *** verif/pao_core_assertions.sv ***
// port checker for the converter output path
`timescale 1ns/1ps
`default_nettype none
module pao_core_checker
  import pao_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              conv_clk,
  input wire logic [DATA_W-1:0] sample_in,
  input wire logic              out_en_n,
  input wire logic              power_down,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [DATA_W-1:0] data_oe,
  input wire logic              data_valid,
  input wire logic              sample_phase
);
  logic [3:0] since_rise;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since the last convert edge, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rise <= 4'hf;
    end else if ($rose(conv_clk)) begin
      since_rise <= 4'h0;
    end else if (since_rise != 4'hf) begin
      since_rise <= since_rise + 4'h1;
    end
  end
  a_reset_word: assert property ($rose(rst_n) |-> data_out == 10'h200 && data_oe == '0 && !data_valid)
    else $error("reset outputs wrong");
  a_oe_hiz: assert property (out_en_n [*6] |-> data_oe == '0)
    else $error("pins driven while disabled");
  a_oe_drive: assert property ((!out_en_n && !power_down) [*6] |-> data_oe == '1)
    else $error("pins not driven while enabled");
  a_pd_hiz: assert property (power_down [*6] |-> data_oe == '0)
    else $error("pins driven in power-down");
  a_pd_quiet: assert property (power_down [*6] |-> !data_valid)
    else $error("word flagged in power-down");
  a_valid_pulse: assert property (data_valid |=> !data_valid)
    else $error("valid longer than one cycle");
  a_word_hold: assert property (!data_valid |-> $stable(data_out))
    else $error("word changed without valid");
  a_valid_near_edge: assert property (data_valid |-> since_rise <= 4'd10)
    else $error("word not tied to a convert edge");
  a_phase_follow: assert property (($rose(conv_clk) && !power_down) |-> ##[1:5] sample_phase)
    else $error("no sample phase after edge");
  c_word: cover property (data_valid);
  c_pd_exit: cover property (power_down ##1 !power_down);
  c_oe_back: cover property (out_en_n ##1 !out_en_n);
endmodule
bind pao_core pao_core_checker #(.DATA_W(DATA_W)) pao_core_checker_inst (
  .clk(clk), .rst_n(rst_n), .conv_clk(conv_clk), .sample_in(sample_in),
  .out_en_n(out_en_n), .power_down(power_down), .data_out(data_out),
  .data_oe(data_oe), .data_valid(data_valid), .sample_phase(sample_phase));
`default_nettype wire

// *** verif/pao_host.sv ***
// capture-side model: convert clock source and record of sent samples
`timescale 1ns/1ps
`default_nettype none
module pao_host
  import pao_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      run,
  input  wire logic      slow,
  output var  logic      conv_clk,
  output var  pao_word_t sample_in
);
  pao_word_t sent[$];
  pao_word_t plan[$];
  int        edges = 0;
  // sample set one clk ahead of the rise and held the whole period,
  // since the device only reads it three clk after the edge
  // period five clk or more, high two, low three or more
  initial begin
    conv_clk = 1'b0;
    sample_in = 10'h200;
    forever begin
      @(posedge clk);
      if (run && rst_n) begin
        sample_in <= (plan.size() > 0) ? plan.pop_front() : 10'($urandom);
        @(posedge clk);
        conv_clk <= 1'b1;
        sent.push_back(sample_in);
        edges++;
        repeat (2) @(posedge clk);
        conv_clk <= 1'b0;
        @(posedge clk);
        if (slow) repeat ($urandom % 4) @(posedge clk);
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the converter output path
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pao_pkg::*;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      out_en_n = 1'b0;
  logic      power_down = 1'b0;
  logic      run = 1'b0;
  logic      slow = 1'b0;
  logic      conv_clk;
  logic      data_valid;
  logic      sample_phase;
  pao_word_t sample_in;
  pao_word_t data_out;
  pao_word_t data_oe;
  pao_word_t exp;
  int        err_count = 0;
  int        n_compared = 0;
  int        corner [5] = '{4, -4, 0, 3, -1};
  always #10 clk = ~clk;
  pao_core pao_core_inst (.clk(clk), .rst_n(rst_n), .conv_clk(conv_clk),
    .sample_in(sample_in), .out_en_n(out_en_n), .power_down(power_down),
    .data_out(data_out), .data_oe(data_oe), .data_valid(data_valid),
    .sample_phase(sample_phase));
  pao_host pao_host_inst (.clk(clk), .rst_n(rst_n), .run(run), .slow(slow),
    .conv_clk(conv_clk), .sample_in(sample_in));
  // --------------------------------------------------------------
  // checks and helpers
  // --------------------------------------------------------------
  task automatic cmp_word(input string what, input pao_word_t e, input pao_word_t g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic cmp_cnt(input string what, input int e, input int g);
    n_compared++;
    if (g != e) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, e, g);
    end
  endtask
  // code for q quarters of half scale from midscale, top clipped to all ones
  function automatic pao_word_t fs_code(input int q);
    int v;
    v = 512 + q * 128;
    return (v > 1023) ? 10'h3ff : 10'(v);
  endfunction
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_word("reset word", 10'h200, data_out);
    cmp_word("reset enables", '0, data_oe);
    rst_n <= 1'b1;
    pao_host_inst.sent.delete();
    @(posedge clk);
  endtask
  // five samples always stay inside the pipe once the clock stops
  task automatic run_edges(input int n, input logic s);
    int k;
    k = pao_host_inst.edges + n;
    slow <= s;
    run <= 1'b1;
    for (int i = 0; i < 2000 && pao_host_inst.edges < k; i++) @(posedge clk);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    cmp_cnt("words in flight", 5, pao_host_inst.sent.size());
  endtask
  // each flagged word is the oldest sample not yet returned
  // one word latched per flag
  always @(posedge clk) begin
    if (rst_n && data_valid) begin
      if (pao_host_inst.sent.size() == 0) cmp_cnt("spare word", 0, 1);
      else begin
        exp = pao_host_inst.sent.pop_front();
        cmp_word("word", exp, data_out);
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test;
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'h9a02a26d));
    do_reset();
    foreach (corner[i]) pao_host_inst.plan.push_back(fs_code(corner[i]));
    run_edges(30, 1'b0);
    run_edges(30, 1'b1);
    // enable only moved while the clock is stopped
    out_en_n <= 1'b1;
    repeat (6) @(posedge clk);
    cmp_word("enables off", '0, data_oe);
    out_en_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmp_word("enables on", '1, data_oe);
    run <= 1'b1;
    repeat (15) @(posedge clk);
    power_down <= 1'b1;
    repeat (20) @(posedge clk);
    cmp_word("power-down enables", '0, data_oe);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    power_down <= 1'b0;
    repeat (6) @(posedge clk);
    pao_host_inst.sent.delete();
    run_edges(12, 1'b0);
    do_reset();
    run_edges(8, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
